// [rtl/duhp_pkg.sv]
// Behaviour
// - Host port carries 8 data bits, 3 address lines, separate read and write strobes.
// - Bus cycles are sampled on clk, the baud oscillator, but never wait on the baud tick.
// - Both channels share one data bus; a channel drives it only when read-selected.
// - A reset pulse over 40 ns returns both channels to their default state.
// - First convention: one low-active select per channel; both low selects both for a write, and a read with both low is not taken.
// - Second convention: one select, extra address bit picks channel, ignored otherwise.
// - Convention select high chooses the first convention, low the second.
// - Reset pin is active high in the first convention, active low in the second.
// - FIFOs off: receive-ready low with byte held; transmit-ready low when holding empty.
// - FIFOs on without block mode is single-character mode; control bit 3 enables block.
// - Single-character mode: receive-ready low with data; transmit-ready low when empty.
// - Block mode: receive-ready falls at trigger or time-out, rises on empty or error.
// - Block mode: transmit-ready low below trigger, high once transmit FIFO is full.
// - Line status shows transmitter fully empty and transmit room available.
// - FIFOs off: transmit interrupt low with byte held, high when empty or shifter idle.
// - FIFOs on: transmit interrupt low above trigger, high below trigger or idle.
// - FIFOs on: receive interrupt low below trigger, high above trigger.
// - One clock feeds both channels' baud generators and also clocks the bus logic.
package duhp_pkg;
    localparam int NUM_CH = 2;
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] FIFO_DEPTH = 7'h40;
    localparam int FCR_FIFO_EN_BIT = 0;
    localparam int FCR_BLOCK_BIT = 3;
    localparam int LSR_TX_ROOM_BIT = 5;
    localparam int LSR_TX_EMPTY_BIT = 6;
    localparam int LSR_FIFO_ERR_BIT = 7;
    localparam logic [DATA_W-1:0] FCR_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FIFO_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_LINE_STATUS = 3'h5;
    localparam logic RX_READY_N_RESET = 1'b1;
    localparam logic TX_READY_N_RESET = 1'b0;
    localparam logic IRQ_RESET = 1'b0;
    localparam int CLK_PERIOD_NS = 40;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_MIN_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_MIN_CYC = (RESET_MIN_RAW < 1) ? 1 : RESET_MIN_RAW;
    localparam int RST_CNT_W = 4;
    localparam logic [RST_CNT_W-1:0] RESET_MIN_CNT = 4'(RESET_MIN_CYC);
    localparam int BAUD_W = 4;
    localparam logic [BAUD_W-1:0] BAUD_LAST = 4'hf;
    localparam int SYNC_W = 18;
    // The reset pin idles low in the first convention, so its bit resets low: no false reset.
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 18'h2ffff;
    localparam int SY_MODE = 17;
    localparam int SY_RST = 16;
    localparam int SY_CSA = 15;
    localparam int SY_CSB = 14;
    localparam int SY_A3 = 13;
    localparam int SY_RD = 12;
    localparam int SY_WR = 11;
    localparam int SY_ADDR = 8;
    localparam int SY_DATA = 0;

    typedef enum logic [1:0]
    {
        BUS_IDLE = 2'b00,
        BUS_READ = 2'b01,
        BUS_WRITE = 2'b10
    } duhp_bus_state_t;
endpackage : duhp_pkg

// [rtl/duhp_chan_pins.sv]
module duhp_chan_pins
    import duhp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic chanRst,
    input wire logic wrEn,
    input wire logic [ADDR_W-1:0] wrAddr,
    input wire logic [DATA_W-1:0] wrData,
    input wire logic [ADDR_W-1:0] rdAddr,
    input wire logic [DATA_W-1:0] coreRdData,
    input wire logic [CNT_W-1:0] rxLevel,
    input wire logic [CNT_W-1:0] txLevel,
    input wire logic [CNT_W-1:0] rxTrig,
    input wire logic [CNT_W-1:0] txTrig,
    input wire logic txShiftEmpty,
    input wire logic rxTimeout,
    input wire logic fifoErr,
    input wire logic autoDir,
    output logic [DATA_W-1:0] rdData,
    output logic fifoEnable,
    output logic blockMode,
    output logic rxReadyN,
    output logic txReadyN,
    output logic irq
);
    logic [DATA_W-1:0] fifoCtrl_reg, fifoCtrl_next, lsrRead;
    logic rxReadyN_reg, rxReadyN_next, txReadyN_reg, txReadyN_next;
    logic irq_reg, irq_next;
    logic fifoOn, blockOn, rxAny, txAny, txFull, txBelow, rxAtTrig;
    logic xmitEmpty, txRoom, rxBlk, txBlk, txIrqOff, txIrqOn, rxIrq;

    assign fifoOn = fifoCtrl_reg[FCR_FIFO_EN_BIT];
    assign blockOn = fifoOn && fifoCtrl_reg[FCR_BLOCK_BIT];
    assign rxAny = rxLevel != '0;
    assign txAny = txLevel != '0;
    assign txFull = txLevel == FIFO_DEPTH;
    assign txBelow = txLevel < txTrig;
    assign rxAtTrig = rxLevel >= rxTrig;
    assign xmitEmpty = !txAny && txShiftEmpty;
    assign txRoom = fifoOn ? !txFull : !txAny;

    // Emptying or an error wins over a trigger in the same cycle, so a stale byte never stalls.
    assign rxBlk = (!rxAny || fifoErr) ? 1'b1 : ((rxAtTrig || rxTimeout) ? 1'b0 : rxReadyN_reg);
    assign txBlk = txBelow ? 1'b0 : (txFull ? 1'b1 : txReadyN_reg);
    assign rxReadyN_next = blockOn ? rxBlk : !rxAny;
    assign txReadyN_next = blockOn ? txBlk : txAny;

    assign txIrqOff = autoDir ? xmitEmpty : !txAny;
    assign txIrqOn = autoDir ? xmitEmpty : (txBelow || !txAny);
    assign rxIrq = fifoOn ? rxAtTrig : rxAny;
    assign irq_next = (fifoOn ? txIrqOn : txIrqOff) || rxIrq;

    assign fifoCtrl_next = (wrEn && wrAddr == ADDR_FIFO_CTRL) ? wrData : fifoCtrl_reg;

    always_comb
    begin
        lsrRead = coreRdData;
        lsrRead[LSR_TX_ROOM_BIT] = txRoom;
        lsrRead[LSR_TX_EMPTY_BIT] = xmitEmpty;
        lsrRead[LSR_FIFO_ERR_BIT] = fifoErr;
    end

    assign rdData = (rdAddr == ADDR_LINE_STATUS) ? lsrRead : coreRdData;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            fifoCtrl_reg <= FCR_RESET;
            rxReadyN_reg <= RX_READY_N_RESET;
            txReadyN_reg <= TX_READY_N_RESET;
            irq_reg <= IRQ_RESET;
        end
        else if (chanRst)
        begin
            fifoCtrl_reg <= FCR_RESET;
            rxReadyN_reg <= RX_READY_N_RESET;
            txReadyN_reg <= TX_READY_N_RESET;
            irq_reg <= IRQ_RESET;
        end
        else
        begin
            fifoCtrl_reg <= fifoCtrl_next;
            rxReadyN_reg <= rxReadyN_next;
            txReadyN_reg <= txReadyN_next;
            irq_reg <= irq_next;
        end
    end

    assign fifoEnable = fifoOn;
    assign blockMode = fifoCtrl_reg[FCR_BLOCK_BIT];
    assign rxReadyN = rxReadyN_reg;
    assign txReadyN = txReadyN_reg;
    assign irq = irq_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset || chanRst);

    sequence s_rx_reach;
        blockOn && rxAny && !fifoErr && (rxAtTrig || rxTimeout);
    endsequence
    sequence s_rx_drain;
        blockOn && !rxAny;
    endsequence

    property p_rx_nofifo;
        !fifoOn |=> (rxReadyN_reg == !$past(rxAny));
    endproperty
    a_rx_nofifo: assert property (p_rx_nofifo) else $error("receive-ready wrong, FIFO off");
    property p_rx_single;
        (fifoOn && !blockOn && rxAny) |=> !rxReadyN_reg;
    endproperty
    a_rx_single: assert property (p_rx_single) else $error("receive-ready high with data");
    property p_rx_block;
        s_rx_reach |=> (!rxReadyN_reg and (s_rx_drain |=> rxReadyN_reg));
    endproperty
    a_rx_block: assert property (p_rx_block) else $error("block receive-ready sequence wrong");
    property p_tx_full;
        (blockOn && txFull && !txBelow) |=> txReadyN_reg;
    endproperty
    a_tx_full: assert property (p_tx_full) else $error("transmit-ready low with FIFO full");
    property p_tx_irq_off;
        (!fifoOn && !autoDir && !txAny) |=> irq_reg;
    endproperty
    a_tx_irq_off: assert property (p_tx_irq_off) else $error("no interrupt with holding empty");
    property p_rx_irq;
        (fifoOn && rxAtTrig) |=> irq_reg;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("no interrupt at receive trigger");
endmodule : duhp_chan_pins

// [rtl/duhp_host_port.sv]
module duhp_host_port
    import duhp_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic busModeSel,
    input wire logic resetPin,
    input wire logic chanASelectN,
    input wire logic chanBSelectN,
    input wire logic channelAddrBit,
    input wire logic readStrobeN,
    input wire logic writeStrobeN,
    input wire logic [ADDR_W-1:0] hostAddr,
    input wire logic [DATA_W-1:0] dataIn,
    input wire logic [NUM_CH-1:0][DATA_W-1:0] coreRdData,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] rxLevel,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] txLevel,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] rxTrig,
    input wire logic [NUM_CH-1:0][CNT_W-1:0] txTrig,
    input wire logic [NUM_CH-1:0] txShiftEmpty,
    input wire logic [NUM_CH-1:0] rxTimeout,
    input wire logic [NUM_CH-1:0] fifoErr,
    input wire logic [NUM_CH-1:0] autoDir,
    output logic [DATA_W-1:0] dataOut,
    output logic dataOe,
    output logic [NUM_CH-1:0] regRead,
    output logic [NUM_CH-1:0] regWrite,
    output logic [ADDR_W-1:0] regAddr,
    output logic [DATA_W-1:0] regWdata,
    output logic chanReset,
    output logic baudTick,
    output logic [NUM_CH-1:0] fifoEnable,
    output logic [NUM_CH-1:0] blockMode,
    output logic [NUM_CH-1:0] rxReadyN,
    output logic [NUM_CH-1:0] txReadyN,
    output logic chanAIrq,
    output logic chanBIrq
);
    // Every host pin is asynchronous to clk, so all of them pass two flip-flops first.
    logic [SYNC_W-1:0] syncIn, sync1_reg, sync2_reg;

    assign syncIn = {busModeSel, resetPin, chanASelectN, chanBSelectN, channelAddrBit,
                     readStrobeN, writeStrobeN, hostAddr, dataIn};

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end
        else
        begin
            sync1_reg <= syncIn;
            sync2_reg <= sync1_reg;
        end
    end

    logic mode16, rstLevel, csA, csB, a3, rdAct, wrAct;
    logic [ADDR_W-1:0] sAddr;
    logic [DATA_W-1:0] sData;

    assign mode16 = sync2_reg[SY_MODE];
    assign rstLevel = sync2_reg[SY_RST];
    assign csA = !sync2_reg[SY_CSA];
    assign csB = !sync2_reg[SY_CSB];
    assign a3 = sync2_reg[SY_A3];
    assign rdAct = !sync2_reg[SY_RD];
    assign wrAct = !sync2_reg[SY_WR];
    assign sAddr = sync2_reg[SY_ADDR +: ADDR_W];
    assign sData = sync2_reg[SY_DATA +: DATA_W];

    // Channel select: two selects in the first convention, one select plus a3 in the second.
    logic selA, selB, oneSel, anySel;

    assign selA = mode16 ? csA : (csA && !a3);
    assign selB = mode16 ? csB : (csA && a3);
    assign oneSel = selA ^ selB;
    assign anySel = selA || selB;

    // Bus sequencing. A write is taken when its strobe is released, so the data that the
    // host holds at the end of the strobe is what lands, even if it settled late.
    duhp_bus_state_t busState_reg, busState_next;
    logic startRead, startWrite, stayRead, endWrite;

    assign startRead = (busState_reg == BUS_IDLE) && rdAct && oneSel;
    assign startWrite = (busState_reg == BUS_IDLE) && !rdAct && wrAct && anySel;
    assign stayRead = rdAct && oneSel;
    assign endWrite = (busState_reg == BUS_WRITE) && !wrAct;

    always_comb
    begin
        busState_next = busState_reg;
        unique case (busState_reg)
            BUS_IDLE:
            begin
                if (startRead)
                begin
                    busState_next = BUS_READ;
                end
                else if (startWrite)
                begin
                    busState_next = BUS_WRITE;
                end
            end
            BUS_READ:
            begin
                if (!stayRead)
                begin
                    busState_next = BUS_IDLE;
                end
            end
            BUS_WRITE:
            begin
                if (!wrAct)
                begin
                    busState_next = BUS_IDLE;
                end
            end
            default:
            begin
                busState_next = BUS_IDLE;
            end
        endcase
    end

    logic [NUM_CH-1:0] wrSel_reg, wrSel_next;
    logic [ADDR_W-1:0] wrAddr_reg, wrAddr_next;
    logic [DATA_W-1:0] wrData_reg, wrData_next;
    logic latchWr;

    assign latchWr = startWrite || ((busState_reg == BUS_WRITE) && wrAct);
    assign wrSel_next = startWrite ? {selB, selA} : wrSel_reg;
    assign wrAddr_next = latchWr ? sAddr : wrAddr_reg;
    assign wrData_next = latchWr ? sData : wrData_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            busState_reg <= BUS_IDLE;
            wrSel_reg <= '0;
            wrAddr_reg <= '0;
            wrData_reg <= '0;
        end
        else
        begin
            busState_reg <= busState_next;
            wrSel_reg <= wrSel_next;
            wrAddr_reg <= wrAddr_next;
            wrData_reg <= wrData_next;
        end
    end

    // Channel side. Read data is looked up from the live address each cycle of the strobe.
    logic [NUM_CH-1:0][DATA_W-1:0] chanRdData;
    logic [NUM_CH-1:0] irqVec;
    logic chanReset_reg;
    logic [NUM_CH-1:0] regWrite_reg;
    logic [ADDR_W-1:0] regAddr_reg;
    logic [DATA_W-1:0] regWdata_reg;

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chan
        duhp_chan_pins u_chan
        (
            .clk(clk),
            .reset(reset),
            .chanRst(chanReset_reg),
            .wrEn(regWrite_reg[g]),
            .wrAddr(regAddr_reg),
            .wrData(regWdata_reg),
            .rdAddr(sAddr),
            .coreRdData(coreRdData[g]),
            .rxLevel(rxLevel[g]),
            .txLevel(txLevel[g]),
            .rxTrig(rxTrig[g]),
            .txTrig(txTrig[g]),
            .txShiftEmpty(txShiftEmpty[g]),
            .rxTimeout(rxTimeout[g]),
            .fifoErr(fifoErr[g]),
            .autoDir(autoDir[g]),
            .rdData(chanRdData[g]),
            .fifoEnable(fifoEnable[g]),
            .blockMode(blockMode[g]),
            .rxReadyN(rxReadyN[g]),
            .txReadyN(txReadyN[g]),
            .irq(irqVec[g])
        );
    end

    assign chanAIrq = irqVec[CH_A];
    assign chanBIrq = irqVec[CH_B];

    // Host-facing outputs.
    logic [DATA_W-1:0] dataOut_reg, dataOut_next;
    logic dataOe_reg, dataOe_next;
    logic [NUM_CH-1:0] regRead_reg, regRead_next, regWrite_next;
    logic [ADDR_W-1:0] regAddr_next;
    logic [DATA_W-1:0] regWdata_next;

    assign dataOe_next = busState_next == BUS_READ;
    assign dataOut_next = dataOe_next ? chanRdData[selB] : '0;
    assign regRead_next = startRead ? {selB, selA} : '0;
    assign regWrite_next = endWrite ? wrSel_reg : '0;
    assign regAddr_next = endWrite ? wrAddr_reg : (startRead ? sAddr : regAddr_reg);
    assign regWdata_next = endWrite ? wrData_reg : regWdata_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dataOut_reg <= '0;
            dataOe_reg <= 1'b0;
            regRead_reg <= '0;
            regWrite_reg <= '0;
            regAddr_reg <= '0;
            regWdata_reg <= '0;
        end
        else
        begin
            dataOut_reg <= dataOut_next;
            dataOe_reg <= dataOe_next;
            regRead_reg <= regRead_next;
            regWrite_reg <= regWrite_next;
            regAddr_reg <= regAddr_next;
            regWdata_reg <= regWdata_next;
        end
    end

    // Reset pin: polarity follows the bus convention; it must stay active for the minimum
    // pulse width before the channels are cleared; at one cycle, a single-cycle pulse already clears them.
    logic pinActive, chanReset_next;
    logic [RST_CNT_W-1:0] rstCnt_reg, rstCnt_next;

    assign pinActive = mode16 ? rstLevel : !rstLevel;
    assign rstCnt_next = !pinActive ? '0 :
        ((rstCnt_reg == RESET_MIN_CNT) ? rstCnt_reg : rstCnt_reg + 4'h1);
    assign chanReset_next = pinActive && (rstCnt_next >= RESET_MIN_CNT);

    // One prescaler serves both channels; bus transfers above never wait on it.
    logic [BAUD_W-1:0] baudCnt_reg, baudCnt_next;
    logic baudTick_reg, baudTick_next;

    assign baudCnt_next = baudCnt_reg + 4'h1;
    assign baudTick_next = baudCnt_reg == BAUD_LAST;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rstCnt_reg <= '0;
            chanReset_reg <= 1'b0;
            baudCnt_reg <= '0;
            baudTick_reg <= 1'b0;
        end
        else
        begin
            rstCnt_reg <= rstCnt_next;
            chanReset_reg <= chanReset_next;
            baudCnt_reg <= baudCnt_next;
            baudTick_reg <= baudTick_next;
        end
    end

    assign dataOut = dataOut_reg;
    assign dataOe = dataOe_reg;
    assign regRead = regRead_reg;
    assign regWrite = regWrite_reg;
    assign regAddr = regAddr_reg;
    assign regWdata = regWdata_reg;
    assign chanReset = chanReset_reg;
    assign baudTick = baudTick_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_pin_held;
        pinActive ##1 pinActive;
    endsequence
    sequence s_write_cycle;
        startWrite ##[1:8] endWrite;
    endsequence

    property p_oe_read;
        dataOe_reg |-> ($past(rdAct) && $past(oneSel));
    endproperty
    a_oe_read: assert property (p_oe_read) else $error("bus driven without single read");
    property p_dual_read;
        (busState_reg == BUS_IDLE && rdAct && selA && selB) |=> !dataOe_reg;
    endproperty
    a_dual_read: assert property (p_dual_read) else $error("bus driven on dual read");
    property p_write_release;
        s_write_cycle |=> (regWrite_reg != '0) ##1 (regWrite_reg == '0);
    endproperty
    a_write_release: assert property (p_write_release) else $error("write not taken once");
    property p_sel_mode68;
        (!mode16 && startWrite) |=> (wrSel_reg == ($past(a3) ? 2'b10 : 2'b01));
    endproperty
    a_sel_mode68: assert property (p_sel_mode68) else $error("address bit select wrong");
    property p_sel_mode16;
        (mode16 && startWrite) |=> (wrSel_reg == {$past(csB), $past(csA)});
    endproperty
    a_sel_mode16: assert property (p_sel_mode16) else $error("chip select decode wrong");
    property p_reset_hold;
        s_pin_held |=> chanReset_reg;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("held reset pin ignored");
    property p_reset_drop;
        (!pinActive && $past(mode16) == mode16) |=> !chanReset_reg;
    endproperty
    a_reset_drop: assert property (p_reset_drop) else $error("channel reset without pin");
    property p_baud;
        baudTick_reg |=> !baudTick_reg [*8];
    endproperty
    a_baud: assert property (p_baud) else $error("baud tick period wrong");
endmodule : duhp_host_port

// [verif/duhp_host_model.sv]
module duhp_host_model
    import duhp_pkg::*;
(
    input wire logic clk,
    input wire logic [DATA_W-1:0] dataOut,
    input wire logic dataOe,
    output logic busModeSel,
    output logic resetPin,
    output logic chanASelectN,
    output logic chanBSelectN,
    output logic channelAddrBit,
    output logic readStrobeN,
    output logic writeStrobeN,
    output logic [ADDR_W-1:0] hostAddr,
    output logic [DATA_W-1:0] dataIn
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        busModeSel = 1'b1;
        resetPin = 1'b0;
        {chanASelectN, chanBSelectN, readStrobeN, writeStrobeN} = 4'hf;
        channelAddrBit = 1'b0;
        hostAddr = 3'h0;
        dataIn = 8'h00;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic sel(input logic sa, sb, a3, input logic [ADDR_W-1:0] a);
        chanASelectN = sa;
        chanBSelectN = sb;
        channelAddrBit = a3;
        hostAddr = a;
    endtask : sel

    // Strobes are asynchronous levels; they are held long enough for the pin synchronisers.
    task automatic wr(input logic sa, sb, a3, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        sel(sa, sb, a3, a);
        dataIn = d;
        step(1);
        writeStrobeN = 1'b0;
        step(4);
        writeStrobeN = 1'b1;
        step(1);
        sel(1'b1, 1'b1, 1'b0, 3'h0);
        dataIn = ~d;
        step(4);
    endtask : wr

    task automatic rd(input logic sa, sb, a3, input logic [ADDR_W-1:0] a,
        output logic [7:0] d, output logic oe);
        if (busModeSel && !sa && !sb) sb = 1'b1;
        sel(sa, sb, a3, a);
        step(1);
        readStrobeN = 1'b0;
        step(4);
        d = dataOut;
        oe = dataOe;
        readStrobeN = 1'b1;
        step(1);
        sel(1'b1, 1'b1, 1'b0, 3'h0);
        step(4);
    endtask : rd

    // The reset pin polarity follows the convention, so idle is its inverse.
    task automatic mode(input logic m);
        busModeSel = m;
        resetPin = !m;
        step(6);
    endtask : mode

    task automatic rst_pulse;
        resetPin = busModeSel;
        step(2);
        resetPin = !busModeSel;
        step(4);
    endtask : rst_pulse
endmodule : duhp_host_model

// [verif/duhp_host_port_test.sv]
module duhp_host_port_test
    import duhp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic busModeSel, resetPin, chanASelectN, chanBSelectN, channelAddrBit;
    logic readStrobeN, writeStrobeN, dataOe, chanAIrq, chanBIrq, baudTick;
    logic [ADDR_W-1:0] hostAddr;
    logic [DATA_W-1:0] dataIn, dataOut, d;
    logic [NUM_CH-1:0][DATA_W-1:0] coreRd = {8'ha5, 8'h5a};
    logic [NUM_CH-1:0][CNT_W-1:0] rxLv = '0, txLv = '0, rxTg = {2{7'h04}}, txTg = {2{7'h04}};
    logic [NUM_CH-1:0] fifoEn, blkMode, rxRdyN, txRdyN;
    logic [NUM_CH-1:0] regRd, regWr, shEmp = 2'h3, rxTo = '0, fErr = '0, aDir = '0;
    logic [ADDR_W-1:0] regAd;
    logic [DATA_W-1:0] regWd;
    logic chanRst;
    logic [12:0] lastWr = '0;
    logic [4:0] lastRd = '0;
    logic [7:0] rstHigh = '0;
    logic oe;
    int errors = 0;
    int checks_done = 0;
    int n;

    always #20 clk = ~clk;

    duhp_host_model duhp_host_model_inst (.clk(clk), .dataOut(dataOut), .dataOe(dataOe),
        .busModeSel(busModeSel), .resetPin(resetPin), .chanASelectN(chanASelectN),
        .chanBSelectN(chanBSelectN), .channelAddrBit(channelAddrBit),
        .readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN), .hostAddr(hostAddr),
        .dataIn(dataIn));

    duhp_host_port duhp_host_port_inst (.clk(clk), .reset(reset), .busModeSel(busModeSel),
        .resetPin(resetPin), .chanASelectN(chanASelectN), .chanBSelectN(chanBSelectN),
        .channelAddrBit(channelAddrBit), .readStrobeN(readStrobeN),
        .writeStrobeN(writeStrobeN), .hostAddr(hostAddr), .dataIn(dataIn),
        .coreRdData(coreRd), .rxLevel(rxLv), .txLevel(txLv), .rxTrig(rxTg), .txTrig(txTg),
        .txShiftEmpty(shEmp), .rxTimeout(rxTo), .fifoErr(fErr), .autoDir(aDir),
        .dataOut(dataOut), .dataOe(dataOe), .regRead(regRd), .regWrite(regWr),
        .regAddr(regAd), .regWdata(regWd), .chanReset(chanRst), .baudTick(baudTick),
        .fifoEnable(fifoEn),
        .blockMode(blkMode), .rxReadyN(rxRdyN), .txReadyN(txRdyN), .chanAIrq(chanAIrq),
        .chanBIrq(chanBIrq));

    // Pulsed outputs are caught here so that the scenarios can look at them later.
    always @(posedge clk)
    begin
        if (regWr != '0)
            lastWr <= {regWr, regAd, regWd};
        if (regRd != '0)
            lastRd <= {regRd, regAd};
        rstHigh <= rstHigh + 8'(chanRst);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic wrap_up;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        duhp_host_model_inst.step(6);
        chk({rxRdyN, txRdyN}, {{2{RX_READY_N_RESET}}, {2{TX_READY_N_RESET}}});
        chk({chanAIrq, chanBIrq, dataOe}, 8'h06);
        duhp_host_model_inst.rd(0, 1, 0, 3'h0, d, oe);
        chk({d, oe}, {8'h5a, 1'b1});
        chk(dataOe, 8'h00);
        duhp_host_model_inst.rd(1, 0, 0, 3'h0, d, oe);
        chk(d, 8'ha5);
        chk(lastRd, {2'h2, 3'h0});
        duhp_host_model_inst.rd(1, 1, 0, 3'h0, d, oe);
        chk(oe, 8'h00);
        duhp_host_model_inst.rd(0, 1, 0, ADDR_LINE_STATUS, d, oe);
        chk(d, 8'h7a);
        chk(lastRd, {2'h1, ADDR_LINE_STATUS});
        duhp_host_model_inst.mode(1'b0);
        duhp_host_model_inst.rd(0, 0, 0, 3'h0, d, oe);
        chk(d, 8'h5a);
        duhp_host_model_inst.rd(0, 0, 1, 3'h0, d, oe);
        chk(d, 8'ha5);
        duhp_host_model_inst.mode(1'b1);
        duhp_host_model_inst.rd(0, 1, 1, 3'h0, d, oe);
        chk(d, 8'h5a);
        rxLv[0] = 7'h01;
        txLv[1] = 7'h01;
        settle;
        chk({rxRdyN, txRdyN}, 8'h0a);
        chk({chanAIrq, chanBIrq}, 8'h02);
        duhp_host_model_inst.wr(0, 0, 0, ADDR_FIFO_CTRL, 8'h01);
        chk({fifoEn, blkMode}, 8'h0c);
        chk(lastWr, {2'h3, ADDR_FIFO_CTRL, 8'h01});
        txLv[1] = 7'h02;
        settle;
        chk({rxRdyN, txRdyN}, 8'h0a);
        chk(chanBIrq, 8'h01);
        txLv[1] = 7'h0a;
        settle;
        chk(chanBIrq, 8'h00);
        rxLv[1] = 7'h04;
        settle;
        chk(chanBIrq, 8'h01);
        aDir[0] = 1'b1;
        shEmp[0] = 1'b0;
        settle;
        chk(chanAIrq, 8'h00);
        shEmp[0] = 1'b1;
        settle;
        chk(chanAIrq, 8'h01);
        aDir[0] = 1'b0;
        duhp_host_model_inst.wr(1, 0, 0, ADDR_FIFO_CTRL, 8'h09);
        chk({fifoEn, blkMode}, 8'h0e);
        chk(lastWr, {2'h2, ADDR_FIFO_CTRL, 8'h09});
        chk({rxRdyN[1], txRdyN[1]}, 8'h01);
        rxLv[1] = 7'h02;
        txLv[1] = 7'h02;
        settle;
        chk({rxRdyN[1], txRdyN[1]}, 8'h00);
        rxLv[1] = 7'h00;
        txLv[1] = 7'h0a;
        settle;
        chk({rxRdyN[1], txRdyN[1]}, 8'h02);
        rxLv[1] = 7'h02;
        rxTo[1] = 1'b1;
        settle;
        chk(rxRdyN[1], 8'h00);
        rxTo[1] = 1'b0;
        fErr[1] = 1'b1;
        settle;
        chk(rxRdyN[1], 8'h01);
        fErr[1] = 1'b0;
        txLv[1] = FIFO_DEPTH;
        settle;
        chk(txRdyN[1], 8'h01);
        duhp_host_model_inst.rst_pulse;
        chk({fifoEn, blkMode, txRdyN}, 8'h02);
        duhp_host_model_inst.mode(1'b0);
        duhp_host_model_inst.wr(0, 1, 0, ADDR_FIFO_CTRL, 8'h01);
        chk(fifoEn, 8'h01);
        chk(lastWr, {2'h1, ADDR_FIFO_CTRL, 8'h01});
        duhp_host_model_inst.rst_pulse;
        chk(fifoEn, 8'h00);
        n = 0;
        repeat (32)
        begin
            @(posedge clk);
            #1;
            n += baudTick;
        end
        chk(8'(n), 8'h02);
        chk(rstHigh, 8'h04);
        wrap_up;
    end

    // The whole sequence needs well under 1000 cycles.
    initial
    begin
        #200000;
        errors++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up;
    end
endmodule : duhp_host_port_test
